// File: sbt_consts.svh
// Constants of the boundary-scan test port: widths, codes, reset values
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH

`define SBT_IR_W          3
`define SBT_ID_W          32
`define SBT_BSR_W         72
`define SBT_SYNC_W        3

// Instruction encodings; only the all-zero code is fixed
`define SBT_OP_EXTEST     3'h0
`define SBT_OP_IDCODE     3'h1
`define SBT_OP_SAMPLE_Z   3'h2
`define SBT_OP_SAMPLE     3'h4
`define SBT_OP_BYPASS     3'h7

// Arbitrary identification value, bit 0 set
`define SBT_ID_VALUE      32'h0A5C_3001

`define SBT_CAP_IR_LOW    2'h1
`define SBT_TMS_RST_EDGES 5
// Sync flop reset levels: tck low, tms and tdi pulled high
`define SBT_SYNC_RST      3'h3

`endif

// File: sbt_pkg.sv
// Types shared by the boundary-scan test port
package sbt_pkg;

  typedef enum logic [3:0] {
    SBT_TLR,
    SBT_RTI,
    SBT_SEL_DR,
    SBT_CAP_DR,
    SBT_SHIFT_DR,
    SBT_EXIT1_DR,
    SBT_PAUSE_DR,
    SBT_EXIT2_DR,
    SBT_UPD_DR,
    SBT_SEL_IR,
    SBT_CAP_IR,
    SBT_SHIFT_IR,
    SBT_EXIT1_IR,
    SBT_PAUSE_IR,
    SBT_EXIT2_IR,
    SBT_UPD_IR
  } sbt_tap_st_t;

  typedef enum logic [1:0] {
    SBT_PATH_BYP,
    SBT_PATH_ID,
    SBT_PATH_BSR
  } sbt_path_t;

endpackage

// File: sbt_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_sync #(
  parameter int        W       = `SBT_SYNC_W,
  parameter logic [W-1:0] RST_VAL = `SBT_SYNC_RST
) (
  input  wire logic         clk,     // system clock
  input  wire logic         reset_n, // async reset, active low
  input  wire logic [W-1:0] din,     // asynchronous pins
  output logic      [W-1:0] dout     // filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sbt_sync_t;

  sbt_sync_t r;
  sbt_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // Change accepted only when stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.lvl[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.lvl;

endmodule

// File: sbt_tap.sv
// Boundary-scan test access port of a burst SRAM, clocked by system clk
//
// What this block does
// - Sample TMS and TDI on rising TCK
// - Change TDO only on falling TCK
// - TMS and TDI read high when unconnected
// - Shift in at MSB, out at LSB
// - Instruction selects exactly one scan register
// - Five TMS-high edges reach reset state
// - Power-up reset leaves TDO high impedance
// - Three-bit instruction register shifts serially
// - Reset state loads identification instruction
// - Capture-IR loads binary 01 low bits
// - Single bypass bit, cleared at capture
// - Capture-type instructions snapshot the I/O ring
// - Boundary register covers ring, MSB at TDI
// - Identification register captures hardwired 32-bit code
// - Scan data never drives memory pins
// - New instruction takes effect at Update-IR
// - All-zero code samples and floats outputs
// - Sample-Z samples and floats outputs
// - Bypass instruction connects bypass register
// - Update-DR under sample changes nothing
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_tap #(
  parameter int               BSR_W      = `SBT_BSR_W,
  parameter logic [2:0]       OP_EXTEST  = `SBT_OP_EXTEST,
  parameter logic [2:0]       OP_IDCODE  = `SBT_OP_IDCODE,
  parameter logic [2:0]       OP_SAMPLEZ = `SBT_OP_SAMPLE_Z,
  parameter logic [2:0]       OP_SAMPLE  = `SBT_OP_SAMPLE,
  parameter logic [2:0]       OP_BYPASS  = `SBT_OP_BYPASS,
  parameter logic [31:0]      ID_VALUE   = `SBT_ID_VALUE
) (
  input  wire logic             clk,      // system clock, 50 MHz
  input  wire logic             reset_n,  // power-up reset, active low
  input  wire logic             tck,      // test clock pin
  input  wire logic             tms,      // mode select pin
  input  wire logic             tdi,      // serial data in pin
  input  wire logic [BSR_W-1:0] io_ring,  // input and bidir pin levels
  output logic                  tdo,      // serial data out
  output logic                  tdo_oe,   // high while tdo is driven
  output logic                  mem_hiz   // force memory outputs high-Z
);

  typedef struct packed {
    sbt_pkg::sbt_tap_st_t   fsm;
    logic                   tck_q;
    logic [`SBT_IR_W-1:0]   ir_sh;
    logic [`SBT_IR_W-1:0]   ir;
    logic                   hiz;
    logic                   byp;
    logic [`SBT_ID_W-1:0]   idr;
    logic [BSR_W-1:0]       bsr;
    logic                   tdo;
    logic                   tdo_oe;
  } sbt_tap_t;

  sbt_tap_t r;
  sbt_tap_t next_r;

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rise;
  logic fall;

  sbt_sync #(
    .W       (`SBT_SYNC_W),
    .RST_VAL (`SBT_SYNC_RST)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({tck, tms, tdi}),
    .dout    ({tck_s, tms_s, tdi_s})
  );

  // Path decode shared by shifting and output
  function automatic sbt_pkg::sbt_path_t path_of(input logic [2:0] op);
    sbt_pkg::sbt_path_t p;
    p = sbt_pkg::SBT_PATH_BYP;
    if (op == OP_IDCODE) begin
      p = sbt_pkg::SBT_PATH_ID;
    end else if (op == OP_EXTEST || op == OP_SAMPLE || op == OP_SAMPLEZ) begin
      p = sbt_pkg::SBT_PATH_BSR;
    end
    return p;
  endfunction

  // Standard TMS-driven transitions
  function automatic sbt_pkg::sbt_tap_st_t tap_next(input sbt_pkg::sbt_tap_st_t s,
                                                    input logic m);
    sbt_pkg::sbt_tap_st_t n;
    n = s;
    // All sixteen codes are legal states, so no default
    unique case (s)
      sbt_pkg::SBT_TLR: begin
        if (m) begin
          n = sbt_pkg::SBT_TLR;
        end else begin
          n = sbt_pkg::SBT_RTI;
        end
      end
      sbt_pkg::SBT_RTI: begin
        if (m) begin
          n = sbt_pkg::SBT_SEL_DR;
        end else begin
          n = sbt_pkg::SBT_RTI;
        end
      end
      sbt_pkg::SBT_SEL_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_SEL_IR;
        end else begin
          n = sbt_pkg::SBT_CAP_DR;
        end
      end
      sbt_pkg::SBT_CAP_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_EXIT1_DR;
        end else begin
          n = sbt_pkg::SBT_SHIFT_DR;
        end
      end
      sbt_pkg::SBT_SHIFT_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_EXIT1_DR;
        end else begin
          n = sbt_pkg::SBT_SHIFT_DR;
        end
      end
      sbt_pkg::SBT_EXIT1_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_UPD_DR;
        end else begin
          n = sbt_pkg::SBT_PAUSE_DR;
        end
      end
      sbt_pkg::SBT_PAUSE_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_EXIT2_DR;
        end else begin
          n = sbt_pkg::SBT_PAUSE_DR;
        end
      end
      sbt_pkg::SBT_EXIT2_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_UPD_DR;
        end else begin
          n = sbt_pkg::SBT_SHIFT_DR;
        end
      end
      sbt_pkg::SBT_UPD_DR: begin
        if (m) begin
          n = sbt_pkg::SBT_SEL_DR;
        end else begin
          n = sbt_pkg::SBT_RTI;
        end
      end
      sbt_pkg::SBT_SEL_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_TLR;
        end else begin
          n = sbt_pkg::SBT_CAP_IR;
        end
      end
      sbt_pkg::SBT_CAP_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_EXIT1_IR;
        end else begin
          n = sbt_pkg::SBT_SHIFT_IR;
        end
      end
      sbt_pkg::SBT_SHIFT_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_EXIT1_IR;
        end else begin
          n = sbt_pkg::SBT_SHIFT_IR;
        end
      end
      sbt_pkg::SBT_EXIT1_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_UPD_IR;
        end else begin
          n = sbt_pkg::SBT_PAUSE_IR;
        end
      end
      sbt_pkg::SBT_PAUSE_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_EXIT2_IR;
        end else begin
          n = sbt_pkg::SBT_PAUSE_IR;
        end
      end
      sbt_pkg::SBT_EXIT2_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_UPD_IR;
        end else begin
          n = sbt_pkg::SBT_SHIFT_IR;
        end
      end
      sbt_pkg::SBT_UPD_IR: begin
        if (m) begin
          n = sbt_pkg::SBT_SEL_DR;
        end else begin
          n = sbt_pkg::SBT_RTI;
        end
      end
    endcase
    return n;
  endfunction

  function automatic logic floats(input logic [2:0] op);
    return (op == OP_EXTEST) || (op == OP_SAMPLEZ);
  endfunction

  assign rise = tck_s & ~r.tck_q;
  assign fall = ~tck_s & r.tck_q;

  always_comb begin
    next_r       = r;
    next_r.tck_q = tck_s;

    // state and data move on rising TCK only
    if (rise) begin
      // TMS high five edges ends in reset
      next_r.fsm = tap_next(r.fsm, tms_s);

      unique case (r.fsm)
        sbt_pkg::SBT_CAP_IR: begin
          next_r.ir_sh = {r.ir[2], `SBT_CAP_IR_LOW};
        end
        sbt_pkg::SBT_SHIFT_IR: begin
          next_r.ir_sh = {tdi_s, r.ir_sh[2:1]};
        end
        sbt_pkg::SBT_CAP_DR: begin
          unique case (path_of(r.ir))
            sbt_pkg::SBT_PATH_BYP: next_r.byp = 1'b0;
            sbt_pkg::SBT_PATH_ID:  next_r.idr = ID_VALUE;
            sbt_pkg::SBT_PATH_BSR: next_r.bsr = io_ring;
            default:               next_r.byp = 1'b0;
          endcase
        end
        sbt_pkg::SBT_SHIFT_DR: begin
          unique case (path_of(r.ir))
            sbt_pkg::SBT_PATH_BYP: next_r.byp = tdi_s;
            sbt_pkg::SBT_PATH_ID:  next_r.idr = {tdi_s, r.idr[`SBT_ID_W-1:1]};
            sbt_pkg::SBT_PATH_BSR: next_r.bsr = {tdi_s, r.bsr[BSR_W-1:1]};
            default:               next_r.byp = tdi_s;
          endcase
        end
        default: begin
          next_r.fsm = tap_next(r.fsm, tms_s);
        end
      endcase

      if (next_r.fsm == sbt_pkg::SBT_TLR) begin
        next_r.ir  = OP_IDCODE;
        next_r.hiz = floats(OP_IDCODE);
      end
      // shifted code takes effect entering update
      if (next_r.fsm == sbt_pkg::SBT_UPD_IR) begin
        next_r.ir  = r.ir_sh;
        next_r.hiz = floats(r.ir_sh);
      end
    end

    if (fall) begin
      next_r.tdo_oe = (r.fsm == sbt_pkg::SBT_SHIFT_IR) || (r.fsm == sbt_pkg::SBT_SHIFT_DR);
      if (r.fsm == sbt_pkg::SBT_SHIFT_IR) begin
        next_r.tdo = r.ir_sh[0];
      end else if (r.fsm == sbt_pkg::SBT_SHIFT_DR) begin
        unique case (path_of(r.ir))
          sbt_pkg::SBT_PATH_BYP: next_r.tdo = r.byp;
          sbt_pkg::SBT_PATH_ID:  next_r.tdo = r.idr[0];
          sbt_pkg::SBT_PATH_BSR: next_r.tdo = r.bsr[0];
          default:               next_r.tdo = r.byp;
        endcase
      end
    end
  end

  // power-up reset: identification loaded, tdo released
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r.fsm    <= sbt_pkg::SBT_TLR;
      r.tck_q  <= 1'b0;
      r.ir_sh  <= OP_IDCODE;
      r.ir     <= OP_IDCODE;
      r.hiz    <= 1'b0;
      r.byp    <= 1'b0;
      r.idr    <= '0;
      r.bsr    <= '0;
      r.tdo    <= 1'b0;
      r.tdo_oe <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign tdo     = r.tdo;
  assign tdo_oe  = r.tdo_oe;
  assign mem_hiz = r.hiz;

endmodule

// File: sbt_tap_props.sv
// Port-level checker for the boundary-scan test port
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_tap_props #(
  parameter int BSR_W = `SBT_BSR_W
) (
  input wire logic             clk,     // system clock
  input wire logic             reset_n, // reset, active low
  input wire logic             tck,     // test clock pin
  input wire logic             tms,     // mode select pin
  input wire logic             tdi,     // serial in pin
  input wire logic [BSR_W-1:0] io_ring, // ring levels
  input wire logic             tdo,     // serial out
  input wire logic             tdo_oe,  // out enable
  input wire logic             mem_hiz  // memory float
);
  logic [3:0] f_age;
  logic [3:0] r_age;
  logic [3:0] i_age;
  logic [2:0] run;
  logic       l_tms;
  // Ages saturate so long idle spells stay recognisable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f_age <= 4'hF;
      r_age <= 4'hF;
      i_age <= 4'h0;
      run   <= 3'h0;
      l_tms <= 1'b1;
    end else begin
      f_age <= $fell(tck) ? 4'h0 : f_age + {3'h0, f_age != 4'hF};
      r_age <= $rose(tck) ? 4'h0 : r_age + {3'h0, r_age != 4'hF};
      i_age <= $changed(tck) ? 4'h0 : i_age + {3'h0, i_age != 4'hF};
      if ($rose(tck)) begin
        l_tms <= tms;
        run   <= tms ? run + {2'h0, run != 3'h7} : 3'h0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_off;
    !tdo_oe && !mem_hiz;
  endsequence
  sequence s_quiet;
    $stable(tdo) && $stable(tdo_oe) && $stable(mem_hiz);
  endsequence
  property p_tdo_fall;
    $changed(tdo) |-> f_age inside {[2:7]};
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved away from a tck fall");
  property p_oe_fall;
    $changed(tdo_oe) |-> f_age inside {[2:7]};
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved away from a tck fall");
  property p_oe_on;
    $rose(tdo_oe) |-> !l_tms;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("tdo_oe rose without tms low");
  property p_oe_off;
    $fell(tdo_oe) |-> l_tms;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("tdo_oe fell without tms high");
  property p_hiz_upd;
    $changed(mem_hiz) |-> l_tms && !tdo_oe && r_age inside {[2:7]};
  endproperty
  a_hiz_upd: assert property (p_hiz_upd) else $error("mem_hiz moved outside an update");
  property p_tms_rst;
    (run >= 3'h5) && $fell(tck) |-> ##[1:9] s_off;
  endproperty
  a_tms_rst: assert property (p_tms_rst) else $error("five tms highs did not reset");
  property p_pwr_rst;
    $rose(reset_n) |-> s_off;
  endproperty
  a_pwr_rst: assert property (p_pwr_rst) else $error("outputs active after reset");
  property p_idle;
    i_age == 4'hF |-> s_quiet;
  endproperty
  a_idle: assert property (p_idle) else $error("outputs moved with tck still");
endmodule

bind sbt_tap sbt_tap_props #(.BSR_W(BSR_W)) sbt_tap_props_i (.clk(clk), .reset_n(reset_n), .tck(tck),
  .tms(tms), .tdi(tdi), .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz));

// File: sbt_ctl_model.sv
// External test controller model driving the scan pins
`timescale 1ns/1ps

module sbt_ctl_model (
  input  wire logic clk,     // system clock
  input  wire logic tdo,     // serial out
  input  wire logic tdo_oe,  // out enable
  output logic      tck,     // test clock
  output logic      tms,     // mode select
  output logic      tdi,     // serial in
  output logic      got_vld, // sample strobe
  output logic      got_tdo, // sampled tdo
  output logic      got_oe   // sampled enable
);
  initial begin
    tck     = 1'b0;
    tms     = 1'b1;
    tdi     = 1'b1;
    got_vld = 1'b0;
    got_tdo = 1'b0;
    got_oe  = 1'b0;
  end
  task automatic cyc(input logic m, input logic d, input bit chk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    got_tdo = tdo;
    got_oe  = tdo_oe;
    got_vld = chk;
    tck     = 1'b0;
    @(negedge clk);
    got_vld = 1'b0;
  endtask
endmodule

// File: sbt_tap_bench.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_tap_bench;
  localparam int BW = `SBT_BSR_W;
  logic          clk, reset_n, tck, tms, tdi, tdo, tdo_oe, mem_hiz, g_vld, g_tdo, g_oe;
  logic [BW-1:0] io_ring;
  logic [127:0]  d;
  logic [2:0]    ir;
  logic          exp_q[$];
  int            err_total, checks_done;

  sbt_tap sbt_tap_i (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz));
  sbt_ctl_model sbt_ctl_model_i (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi), .got_vld(g_vld), .got_tdo(g_tdo), .got_oe(g_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    if (g_vld) begin
      if (exp_q.size() == 0) chk("queue", 32'h1, 32'h0);
      else chk("tdo", {31'h0, exp_q.pop_front()}, {31'h0, g_tdo});
      chk("tdo_oe", 32'h1, {31'h0, g_oe});
    end
  end

  task automatic mv(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) sbt_ctl_model_i.cyc(m[i], 1'b1, 1'b0);
  endtask

  // Shift n bits, leave via Exit1, Update and idle
  task automatic scan(input int n, input logic [127:0] di, input logic [127:0] e);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      sbt_ctl_model_i.cyc(i == n - 1, di[i], 1'b1);
    end
    mv(8'h01, 2);
  endtask

  task automatic ld(input logic [2:0] op);
    mv(8'h03, 4);
    scan(3, {125'h0, op}, {125'h0, ir[2], 2'h1});
    ir = op;
  endtask

  // Bits past the register length come back from tdi
  task automatic rd(input int n, input int len, input logic [127:0] e);
    d = {$urandom, $urandom, $urandom, $urandom};
    mv(8'h01, 3);
    scan(n, d, e | (d << len));
  endtask

  initial begin
    void'($urandom(32'h7312));
    reset_n = 1'b0;
    io_ring = '0;
    ir      = `SBT_OP_IDCODE;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    chk("tdo_oe", 32'h0, {31'h0, tdo_oe});
    mv(8'h00, 1);
    rd(40, 32, {96'h0, `SBT_ID_VALUE});
    $display("test identification done");
    ld(`SBT_OP_BYPASS);
    d = {$urandom, $urandom, $urandom, $urandom};
    mv(8'h01, 3);
    scan(40, d, d << 1);
    $display("test bypass done");
    io_ring = BW'({$urandom, $urandom, $urandom} >> 24);
    ld(`SBT_OP_SAMPLE);
    rd(BW, BW, {56'h0, io_ring});
    chk("mem_hiz", 32'h0, {31'h0, mem_hiz});
    $display("test sample done");
    for (int k = 0; k < 2; k++) begin
      io_ring = BW'({$urandom, $urandom, $urandom} >> 24);
      ld(k == 0 ? `SBT_OP_EXTEST : `SBT_OP_SAMPLE_Z);
      chk("mem_hiz", 32'h1, {31'h0, mem_hiz});
      rd(BW, BW, {56'h0, io_ring});
    end
    $display("test float codes done");
    mv(8'h1F, 5);
    chk("mem_hiz", 32'h0, {31'h0, mem_hiz});
    ir = `SBT_OP_IDCODE;
    mv(8'h00, 1);
    rd(32, 32, {96'h0, `SBT_ID_VALUE});
    $display("test tms reset done");
    repeat (20) @(negedge clk);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
